// ### src/rx_recovery_pkg.sv
// Package for the asynchronous receive clock and data recovery block.
// Assumes a single system clock domain with an active-low asynchronous reset.
package rx_recovery_pkg;

   // ****************************************************************
   // Oversampling and voting positions
   // ****************************************************************
   localparam logic [4:0] samples_normal = 5'h10;
   localparam logic [4:0] samples_double = 5'h08;
   localparam logic [3:0] vote_first_normal = 4'h8;
   localparam logic [3:0] vote_first_double = 4'h4;
   localparam logic [3:0] vote_mid_normal = 4'h9;
   localparam logic [3:0] vote_mid_double = 4'h5;
   localparam logic [3:0] vote_last_normal = 4'ha;
   localparam logic [3:0] vote_last_double = 4'h6;

   // ****************************************************************
   // Frame geometry and reset values
   // ****************************************************************
   localparam logic [3:0] bits_min = 4'h5;
   localparam logic [3:0] bits_max = 4'ha;
   localparam int baud_divisor_reset = 64;
   localparam int divisor_width = 12;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0]
   {
      st_idle = 2'b00,
      st_start = 2'b01,
      st_bits = 2'b10
   } rx_state_e;

   // One received frame: data plus parity bits (LSB first) and its stop verdict.
   typedef struct packed
   {
      logic [9:0] bits;
      logic frame_error_flag;
   } rx_word_s;

endpackage : rx_recovery_pkg

// ### src/async_rx_clock_data_recovery.sv
// Asynchronous receive clock and data recovery with a two-entry output buffer.
// Assumes rxd is an asynchronous pin and the consumer drains words with ready.
//
// Functional notes
// - Sixteen samples per bit, eight in double speed.
// - Idle watches for high to low edge.
// - Qualify start on samples 8-10 or 4-6.
// - Two high qualify samples reject as noise.
// - Realign bit timing on every valid start.
// - Per-bit state counter, sixteen or eight states.
// - Majority of three centre samples decides bit.
// - Centre sample is state nine or five.
// - Recover through first stop, ignore further stops.
// - Low voted stop bit sets frame error.
// - Ready for next start after last vote.
// - Five to ten data plus parity bits.
// - Double speed halves samples per bit from sixteen to eight.
module async_rx_clock_data_recovery #(
   parameter int divisor_width = rx_recovery_pkg::divisor_width
)(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rxd,
   input wire logic double_speed_select,
   input wire logic [divisor_width-1:0] baud_divisor_value,
   input wire logic [3:0] frame_bits,
   input wire logic out_ready,
   output logic out_valid,
   output rx_recovery_pkg::rx_word_s out_word,
   output logic busy
);

   // ****************************************************************
   // Input synchroniser and sample enable
   // ****************************************************************
   logic sync1_reg, sync2_reg, last_reg;
   logic [divisor_width-1:0] div_reg, div_next;
   logic tick;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end
      else
      begin
         sync1_reg <= rxd;
         sync2_reg <= sync1_reg;
      end
   end

   // The divisor gives the oversample rate; the sample count per bit is applied below.
   always_comb
   begin
      tick = (div_reg == '0);
      div_next = tick ? baud_divisor_value : div_reg - divisor_width'(1);
   end

   // ****************************************************************
   // Recovery state machine
   // ****************************************************************
   rx_recovery_pkg::rx_state_e state_reg, state_next;
   logic [3:0] phase_reg, phase_next;
   logic [3:0] nbit_reg, nbit_next;
   logic [1:0] votes_reg, votes_next;
   logic [9:0] shift_reg, shift_next;
   logic done_pulse;
   rx_recovery_pkg::rx_word_s done_word;
   logic [3:0] v_first, v_last, top, nbits;
   logic maj, is_stop;
   logic last_next;

   always_comb
   begin
      // Double speed uses eight states per bit
      top = double_speed_select ? 4'(rx_recovery_pkg::samples_double - 5'h01)
                                : 4'(rx_recovery_pkg::samples_normal - 5'h01);
      v_first = double_speed_select ? rx_recovery_pkg::vote_first_double
                                    : rx_recovery_pkg::vote_first_normal;
      v_last = double_speed_select ? rx_recovery_pkg::vote_last_double
                                   : rx_recovery_pkg::vote_last_normal;
      // Clamp frame length to five through ten
      nbits = (frame_bits < rx_recovery_pkg::bits_min) ? rx_recovery_pkg::bits_min :
              (frame_bits > rx_recovery_pkg::bits_max) ? rx_recovery_pkg::bits_max : frame_bits;
      state_next = state_reg;
      phase_next = phase_reg;
      nbit_next = nbit_reg;
      votes_next = votes_reg;
      shift_next = shift_reg;
      done_pulse = 1'b0;
      done_word = '0;
      last_next = tick ? sync2_reg : last_reg;
      // Two or three high votes give one
      maj = (votes_reg + {1'b0, sync2_reg}) >= 2'h2;
      is_stop = (nbit_reg == nbits);
      if (tick)
      begin
         case (state_reg)
            rx_recovery_pkg::st_idle:
            begin
               if (last_reg && !sync2_reg)
               begin
                  state_next = rx_recovery_pkg::st_start;
                  phase_next = 4'h1;
                  votes_next = 2'h0;
                  shift_next = 10'h000;
               end
            end
            rx_recovery_pkg::st_start:
            begin
               phase_next = phase_reg + 4'h1;
               if (phase_next >= v_first && phase_next < v_last)
                  votes_next = votes_reg + {1'b0, sync2_reg};
               else if (phase_next == v_last)
               begin
                  if (maj)
                     state_next = rx_recovery_pkg::st_idle;
                  else
                  begin
                     // Bit timing aligned to this start bit
                     state_next = rx_recovery_pkg::st_bits;
                     phase_next = v_last;
                     nbit_next = 4'h0;
                     votes_next = 2'h0;
                  end
               end
            end
            rx_recovery_pkg::st_bits:
            begin
               // State counter wraps once per bit
               phase_next = (phase_reg == top) ? 4'h0 : phase_reg + 4'h1;
               // Votes centred on state nine or five
               if (phase_next >= v_first && phase_next < v_last)
                  votes_next = votes_reg + {1'b0, sync2_reg};
               else if (phase_next == v_last)
               begin
                  votes_next = 2'h0;
                  if (is_stop)
                  begin
                     // Return to idle right after the stop vote
                     state_next = rx_recovery_pkg::st_idle;
                     done_pulse = 1'b1;
                     done_word.bits = shift_reg;
                     // Low stop bit flags frame error
                     done_word.frame_error_flag = !maj;
                  end
                  else
                  begin
                     shift_next = shift_reg;
                     shift_next[nbit_reg] = maj;
                     nbit_next = nbit_reg + 4'h1;
                  end
               end
            end
            default:
               state_next = rx_recovery_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_reg <= '0;
         last_reg <= 1'b1;
         state_reg <= rx_recovery_pkg::st_idle;
         phase_reg <= 4'h0;
         nbit_reg <= 4'h0;
         votes_reg <= 2'h0;
         shift_reg <= 10'h000;
      end
      else
      begin
         div_reg <= div_next;
         last_reg <= last_next;
         state_reg <= state_next;
         phase_reg <= phase_next;
         nbit_reg <= nbit_next;
         votes_reg <= votes_next;
         shift_reg <= shift_next;
      end
   end

   // ****************************************************************
   // Two-entry output buffer
   // ****************************************************************
   // A word finished while both entries are full and out_ready is low is dropped; the consumer must keep up.
   rx_recovery_pkg::rx_word_s buf_reg [2];
   rx_recovery_pkg::rx_word_s buf_next [2];
   logic [1:0] count_reg, count_next;
   logic busy_next, valid_next;

   always_comb
   begin
      buf_next = buf_reg;
      count_next = count_reg;
      if (out_ready && count_reg != 2'h0)
      begin
         buf_next[0] = buf_reg[1];
         count_next = count_reg - 2'h1;
      end
      if (done_pulse && count_next != 2'h2)
      begin
         buf_next[count_next[0]] = done_word;
         count_next = count_next + 2'h1;
      end
      busy_next = (state_next != rx_recovery_pkg::st_idle);
      // The valid flag follows the next count so that it moves in step with the entries.
      valid_next = (count_next != 2'h0);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         buf_reg[0] <= '0;
         buf_reg[1] <= '0;
         count_reg <= 2'h0;
         busy <= 1'b0;
         out_valid <= 1'b0;
      end
      else
      begin
         buf_reg <= buf_next;
         count_reg <= count_next;
         busy <= busy_next;
         out_valid <= valid_next;
      end
   end

   assign out_word = buf_reg[0];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence noise_seen;
      tick && state_reg == rx_recovery_pkg::st_start && phase_next == v_last && maj;
   endsequence

   noise_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
      noise_seen |=> state_reg == rx_recovery_pkg::st_idle)
      else $error("noisy start not rejected");

   stop_error_a: assert property (@(posedge clk) disable iff (!reset_n)
      done_pulse && count_reg == 2'h0 && !out_ready |=> out_word.frame_error_flag == !$past(maj))
      else $error("frame error does not match stop vote");

   idle_after_a: assert property (@(posedge clk) disable iff (!reset_n)
      done_pulse |=> state_reg == rx_recovery_pkg::st_idle)
      else $error("not idle after stop vote");

   phase_range_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_reg == rx_recovery_pkg::st_bits && double_speed_select |-> phase_reg < 4'h8)
      else $error("phase beyond eight states");

   count_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
      count_reg <= 2'h2 && out_valid == (count_reg != 2'h0))
      else $error("buffer count overflow");

   bit_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
      nbit_reg <= rx_recovery_pkg::bits_max)
      else $error("bit index beyond ten");

   start_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(state_reg == rx_recovery_pkg::st_start) |-> phase_reg == 4'h1)
      else $error("start not at sample one");

   align_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(state_reg == rx_recovery_pkg::st_bits) |-> nbit_reg == 4'h0 && phase_reg == v_last)
      else $error("bit timing not realigned");

endmodule : async_rx_clock_data_recovery

// ### bench/serial_tx_model.sv
// Remote asynchronous transmitter driving the serial receive line.
// Assumes the bench calls its tasks at a falling clock edge.
module serial_tx_model (
   input wire logic clk,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;

   initial rxd = 1'b1;

   task automatic hold_line(input logic level, input int cycles);
   begin
      rxd = level;
      repeat (cycles) @(negedge clk);
   end
   endtask : hold_line

   // exact bit rate
   // The period is an exact clock count, so the rate error is zero.
   task automatic send_frame(input logic [9:0] bits, input int count, input logic stop,
      input int period, input int stop_len);
   begin
      hold_line(1'b0, period);
      for (int i = 0; i < count; i++)
         hold_line(bits[i], period);
      hold_line(stop, stop_len);
      rxd = 1'b1;
   end
   endtask : send_frame

   task automatic glitch(input int cycles);
   begin
      hold_line(1'b0, cycles);
      rxd = 1'b1;
   end
   endtask : glitch
endmodule : serial_tx_model

// ### bench/tb_async_rx_clock_data_recovery.sv
// Self-checking bench for the receive recovery block.
// Assumes the transmitter model and the design package are compiled first.
module tb_async_rx_clock_data_recovery;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk;
   logic reset_n;
   logic rxd;
   logic double_speed_select;
   logic [11:0] baud_divisor_value;
   logic [3:0] frame_bits;
   logic out_ready;
   logic out_valid;
   logic busy;
   rx_recovery_pkg::rx_word_s out_word;
   int num_errors;
   int total_checks;

   serial_tx_model serial_tx_model_inst (.clk(clk), .rxd(rxd));

   async_rx_clock_data_recovery async_rx_clock_data_recovery_inst (
      .clk(clk), .reset_n(reset_n), .rxd(rxd), .double_speed_select(double_speed_select),
      .baud_divisor_value(baud_divisor_value), .frame_bits(frame_bits),
      .out_ready(out_ready), .out_valid(out_valid), .out_word(out_word), .busy(busy));

   // ****************************************************************
   // Checking helpers
   // ****************************************************************
   task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
   begin
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask : check

   task automatic give_verdict();
   begin
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask : give_verdict

   // Waits a bounded time for a word, compares it, then pops it.
   task automatic take_word(input logic [9:0] bits, input logic fe);
   begin
      for (int i = 0; i < 400 && out_valid !== 1'b1; i++)
         @(negedge clk);
      check("out_valid", {10'h000, out_valid}, 11'h001);
      check("out_word", out_word, {bits, fe});
      out_ready = 1'b1;
      @(negedge clk);
      out_ready = 1'b0;
      @(negedge clk);
   end
   endtask : take_word

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_normal();
   begin
      double_speed_select = 1'b0;
      frame_bits = 4'h8;
      serial_tx_model_inst.send_frame(10'h0a5, 8, 1'b1, 16, 16);
      take_word(10'h0a5, 1'b0);
   end
   endtask : test_normal

   // Divisor one halves the tick rate, so a double-speed bit is 16 clocks.
   task automatic test_double_frame_error();
   begin
      double_speed_select = 1'b1;
      baud_divisor_value = 12'h001;
      frame_bits = 4'h5;
      serial_tx_model_inst.send_frame(10'h016, 5, 1'b0, 16, 16);
      take_word(10'h016, 1'b1);
      baud_divisor_value = 12'h000;
      double_speed_select = 1'b0;
      repeat (40) @(negedge clk);
   end
   endtask : test_double_frame_error

   task automatic test_noise();
   begin
      serial_tx_model_inst.glitch(6);
      repeat (40) @(negedge clk);
      // Eight low clocks leave exactly two high qualify samples.
      serial_tx_model_inst.glitch(8);
      repeat (300) @(negedge clk);
      check("noise_valid", {10'h000, out_valid}, 11'h000);
      check("noise_busy", {10'h000, busy}, 11'h000);
   end
   endtask : test_noise

   // Short stops start the next frame right after the stop vote.
   task automatic test_stall_back_to_back();
   begin
      frame_bits = 4'ha;
      serial_tx_model_inst.send_frame(10'h3c1, 10, 1'b1, 16, 10);
      serial_tx_model_inst.send_frame(10'h25a, 10, 1'b1, 16, 10);
      serial_tx_model_inst.send_frame(10'h0ff, 10, 1'b1, 16, 16);
      repeat (20) @(negedge clk);
      take_word(10'h3c1, 1'b0);
      take_word(10'h25a, 1'b0);
      check("drop_valid", {10'h000, out_valid}, 11'h000);
   end
   endtask : test_stall_back_to_back

   // Bit 0 is high with one low centre sample, bit 1 low with one high one.
   task automatic test_majority();
   begin
      frame_bits = 4'h5;
      serial_tx_model_inst.hold_line(1'b0, 16);
      serial_tx_model_inst.hold_line(1'b1, 8);
      serial_tx_model_inst.hold_line(1'b0, 1);
      serial_tx_model_inst.hold_line(1'b1, 7);
      serial_tx_model_inst.hold_line(1'b0, 9);
      serial_tx_model_inst.hold_line(1'b1, 1);
      serial_tx_model_inst.hold_line(1'b0, 6);
      serial_tx_model_inst.hold_line(1'b1, 16);
      serial_tx_model_inst.hold_line(1'b0, 16);
      serial_tx_model_inst.hold_line(1'b1, 32);
      take_word(10'h015, 1'b0);
   end
   endtask : test_majority

   // Reset in mid-frame, then a frame whose length setting is above ten.
   task automatic test_reset_mid_frame();
   begin
      frame_bits = 4'hf;
      serial_tx_model_inst.hold_line(1'b0, 24);
      check("mid_busy", {10'h000, busy}, 11'h001);
      reset_n = 1'b0;
      serial_tx_model_inst.hold_line(1'b1, 4);
      check("reset_valid", {10'h000, out_valid}, 11'h000);
      check("reset_busy", {10'h000, busy}, 11'h000);
      check("reset_word", out_word, 11'h000);
      reset_n = 1'b1;
      repeat (10) @(negedge clk);
      serial_tx_model_inst.send_frame(10'h2b3, 10, 1'b1, 16, 16);
      take_word(10'h2b3, 1'b0);
   end
   endtask : test_reset_mid_frame

   // ****************************************************************
   // Clock, reset, sequence and watchdog
   // ****************************************************************
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      num_errors = 0;
      total_checks = 0;
      reset_n = 1'b0;
      double_speed_select = 1'b0;
      baud_divisor_value = 12'h000;
      frame_bits = 4'h8;
      out_ready = 1'b0;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      repeat (10) @(negedge clk);
      test_normal();
      test_double_frame_error();
      test_noise();
      test_majority();
      test_stall_back_to_back();
      test_reset_mid_frame();
      give_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
endmodule : tb_async_rx_clock_data_recovery
